// File: shared/usbsrc_pkg.sv
/*
  Constants, register layouts and state type of the session request
  controller. Assumes a 20 MHz system clock and an 8-bit register port
  into the USB peripheral.
*/
package usbsrc_pkg;

  // ------------------------------------------------------------------
  // Clock and time figures
  // ------------------------------------------------------------------
  localparam longint CLK_HZ       = 20_000_000;
  localparam longint INIT_WAIT_US = 2_100;      // Must exceed 2 ms.
  localparam longint DP_PULSE_US  = 7_000;      // Between 5 ms and 10 ms.
  localparam longint VP_PULSE_US  = 20_000;     // Above 16 ms, below 26 ms.
  localparam longint DISCHG_US    = 30_000;     // Up to 30 ms to fall.
  localparam longint SESS_WAIT_US = 5_000_000;  // Host has up to 5 s.
  localparam longint POLL_US      = 1_000;      // Spacing of flag reads.
  localparam longint DP_MIN_US    = 5_000;
  localparam longint VP_MIN_US    = 16_000;
  localparam longint PULSE_MAX_US = 100_000;
  localparam int     TMR_W        = 27;

  // Least times round up to whole cycles, never below one.
  function automatic int unsigned us_to_cyc(input longint us);
    longint c;
    c = (CLK_HZ * us + 64'd999_999) / 64'd1_000_000;
    return (c < 1) ? 1 : int'(c);
  endfunction

  // ------------------------------------------------------------------
  // Peripheral register (session_request_control)
  // ------------------------------------------------------------------
  localparam logic [7:0] DEV_SRC_ADDR = 8'h12;
  localparam int DR_EN_BIT = 0;   // dual_role_enable
  localparam int VP_BIT    = 1;   // vbus_pulse_ctl
  localparam int DISC_BIT  = 2;   // vbus_discharge_ctl
  localparam int INIT_BIT  = 3;   // init_condition_violation
  localparam int SV_BIT    = 4;   // session_valid_flag
  localparam int DP_BIT    = 5;   // data_line_pulse_ctl
  localparam logic [7:0] CTL_MASK = 8'h27;

  // ------------------------------------------------------------------
  // Software registers on APB
  // ------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] STAT_OFS  = 12'h004;
  localparam int C_START_BIT = 0;
  localparam int C_DISC_BIT  = 1;
  localparam int C_ABORT_BIT = 2;
  localparam int S_BUSY_BIT  = 0;
  localparam int S_DONE_BIT  = 1;
  localparam int S_OK_BIT    = 2;
  localparam int S_INIT_BIT  = 3;
  localparam int S_TOUT_BIT  = 4;
  localparam int S_BRST_BIT  = 5;
  localparam int S_STATE_LSB = 8;
  localparam int S_RD_LSB    = 16;

  typedef enum logic [4:0] {
    ST_IDLE, ST_EN_WR, ST_INIT_CLR, ST_INIT_WAIT, ST_INIT_RD,
    ST_DP_ON, ST_DP_WAIT, ST_DP_OFF, ST_VP_ON, ST_VP_WAIT, ST_VP_OFF,
    ST_DISC_ON, ST_DISC_WAIT, ST_DISC_OFF, ST_SV_CLR, ST_SV_WAIT,
    ST_SV_RD, ST_OFF_OK, ST_OFF_FAIL
  } usbsrc_state_type;

endpackage

// File: shared/usbsrc_sw_if.sv
/*
  Carrier between the APB register slave and the sequencer. Assumes both
  ends run on the same system clock.
*/
`timescale 1ns/1ps
interface usbsrc_sw_if;
  logic       start;
  logic       abort;
  logic       disc_en;
  logic       busy;
  logic       done;
  logic       success;
  logic       init_fail;
  logic       timeout;
  logic       busrst;
  logic [4:0] state;
  logic [7:0] last_rd;

  modport regs (output start, abort, disc_en,
                input  busy, done, success, init_fail, timeout, busrst,
                       state, last_rd);
  modport ctrl (input  start, abort, disc_en,
                output busy, done, success, init_fail, timeout, busrst,
                       state, last_rd);
endinterface

// File: rtl/usbsrc_apb_regs.sv
/*
  APB slave holding the software control and status words of the session
  request controller. Assumes APB3 signalling on the system clock.
*/
`timescale 1ns/1ps
module usbsrc_apb_regs
  import usbsrc_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic [11:0] i_paddr,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  usbsrc_sw_if.regs        sw
);
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        start_ff;
  logic        abort_ff;
  logic        disc_en_ff;
  logic        wr_ctrl;
  logic [31:0] rd_mux;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  // Zero wait states: read data is prepared during the setup cycle.
  assign o_pready = 1'b1;
  assign wr_ctrl  = i_psel && i_penable && i_pwrite && (i_paddr == CTRL_OFS);

  always_comb begin
    rd_mux = '0;
    if (i_paddr == CTRL_OFS) begin
      rd_mux[C_DISC_BIT] = disc_en_ff;
    end else if (i_paddr == STAT_OFS) begin
      rd_mux[S_BUSY_BIT] = sw.busy;
      rd_mux[S_DONE_BIT] = sw.done;
      rd_mux[S_OK_BIT]   = sw.success;
      rd_mux[S_INIT_BIT] = sw.init_fail;
      rd_mux[S_TOUT_BIT] = sw.timeout;
      rd_mux[S_BRST_BIT] = sw.busrst;
      rd_mux[S_STATE_LSB +: 5] = sw.state;
      rd_mux[S_RD_LSB +: 8]    = sw.last_rd;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else if (i_psel && !i_penable) begin
      prdata_ff  <= i_pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_ff <= (i_paddr != CTRL_OFS) && (i_paddr != STAT_OFS);
    end
  end

  // ------------------------------------------------------------------
  // Control word
  // ------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      start_ff   <= 1'b0;
      abort_ff   <= 1'b0;
      disc_en_ff <= 1'b0;
    end else begin
      start_ff <= wr_ctrl && i_pwdata[C_START_BIT];
      abort_ff <= wr_ctrl && i_pwdata[C_ABORT_BIT];
      if (wr_ctrl) begin
        disc_en_ff <= i_pwdata[C_DISC_BIT];
      end
    end
  end

  assign o_prdata   = prdata_ff;
  assign o_pslverr  = pslverr_ff;
  assign sw.start   = start_ff;
  assign sw.abort   = abort_ff;
  assign sw.disc_en = disc_en_ff;
endmodule

// File: rtl/usbsrc_ctrl.sv
/*
  Session request sequencer. It drives the peripheral's session request
  control register through a four-phase register port and reports to
  software over APB. Assumes the peripheral answers each port request with
  an acknowledge level that arrives asynchronously.
*/
`timescale 1ns/1ps
// Function
// - Clear the data-line pulse bit once its phase is over.
// - Session valid still read as 0 once the 5 s wait has run out means the request failed.
// - On session valid, clear dual-role enable then connect the pull-up.
// - Give the host up to 5 s to answer the request.
// - Optional discharge may run after pulsing, before clearing session valid.
// - Clear the initial-condition flag, wait over 2 ms, read it.
// - Initial-condition flag 1 aborts the request; 0 lets it proceed.
// - Discharge bit drains VBUS; allow up to 30 ms.
// - Clear the discharge bit before the session ends.
// - Hold the VBUS pulse bit over 16 ms, clear before 26 ms.
// - Finish both pulse phases before watching session valid.
// - Data-line pulse lasts 5 to 10 ms, then VBUS pulsing starts.
// - Both pulse phases complete within 100 ms.
// - Enable, check, pulse data line, pulse VBUS, discharge, wait, connect.
// - Disabling dual-role writes 0 to both pulse bits.
module usbsrc_ctrl
  import usbsrc_pkg::*;
#(
  parameter int unsigned P_INIT_CYC  = usbsrc_pkg::us_to_cyc(INIT_WAIT_US),
  parameter int unsigned P_DP_CYC    = usbsrc_pkg::us_to_cyc(DP_PULSE_US),
  parameter int unsigned P_VP_CYC    = usbsrc_pkg::us_to_cyc(VP_PULSE_US),
  parameter int unsigned P_DISC_CYC  = usbsrc_pkg::us_to_cyc(DISCHG_US),
  parameter int unsigned P_SESS_CYC  = usbsrc_pkg::us_to_cyc(SESS_WAIT_US),
  parameter int unsigned P_POLL_CYC  = usbsrc_pkg::us_to_cyc(POLL_US),
  parameter int unsigned P_DPMIN_CYC =
    32'(P_DP_CYC * DP_MIN_US / DP_PULSE_US),
  parameter int unsigned P_VPMIN_CYC =
    32'(P_VP_CYC * VP_MIN_US / VP_PULSE_US),
  parameter int unsigned P_PMAX_CYC  = 32'((P_DP_CYC + P_VP_CYC) *
    PULSE_MAX_US / (DP_PULSE_US + VP_PULSE_US))
)(
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic [11:0] i_paddr,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_dev_cs,
  output logic             o_dev_wr,
  output logic      [7:0]  o_dev_addr,
  output logic      [7:0]  o_dev_wdata,
  input  wire logic [7:0]  i_dev_rdata,
  input  wire logic        i_dev_ack,
  input  wire logic        i_bus_reset,
  output logic             o_pullup_connect
);
  import usbsrc_pkg::*;

  if (P_SESS_CYC >= (64'd1 << TMR_W) || P_INIT_CYC < 1 || P_DP_CYC < 1 ||
      P_VP_CYC < 1 || P_DISC_CYC < 1 || P_POLL_CYC < 1) begin : g_chk
    $error("usbsrc_ctrl: timing parameter out of range");
  end

  usbsrc_sw_if sw ();

  usbsrc_apb_regs u_regs (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_paddr   (i_paddr),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_pwdata  (i_pwdata),
    .o_prdata  (o_prdata),
    .o_pready  (o_pready),
    .o_pslverr (o_pslverr),
    .sw        (sw)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic is_xfer(input usbsrc_state_type st);
    case (st)
      ST_EN_WR, ST_INIT_CLR, ST_INIT_RD, ST_DP_ON, ST_DP_OFF, ST_VP_ON,
      ST_VP_OFF, ST_DISC_ON, ST_DISC_OFF, ST_SV_CLR, ST_SV_RD,
      ST_OFF_OK, ST_OFF_FAIL: return 1'b1;
      default:                return 1'b0;
    endcase
  endfunction

  // Every write keeps the enable set except the two that leave dual-role
  // mode, which also zero both pulse bits.
  function automatic logic [7:0] wr_value(input usbsrc_state_type st);
    logic [7:0] v;
    v = 8'h00;
    v[DR_EN_BIT] = 1'b1;
    case (st)
      ST_INIT_CLR: v[INIT_BIT] = 1'b1;
      ST_DP_ON:    v[DP_BIT]   = 1'b1;
      ST_VP_ON:    v[VP_BIT]   = 1'b1;
      ST_DISC_ON:  v[DISC_BIT] = 1'b1;
      ST_SV_CLR:   v[SV_BIT]   = 1'b1;
      ST_OFF_OK, ST_OFF_FAIL: v = 8'h00;
      default:     v = v;
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] ack_sy_ff;
  logic [2:0] brst_sy_ff;
  logic       ack_ff;
  logic       brst_ff;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_sy_ff  <= 3'h0;
      brst_sy_ff <= 3'h0;
      ack_ff     <= 1'b0;
      brst_ff    <= 1'b0;
    end else begin
      ack_sy_ff  <= {ack_sy_ff[1:0], i_dev_ack};
      brst_sy_ff <= {brst_sy_ff[1:0], i_bus_reset};
      if (ack_sy_ff[1] == ack_sy_ff[2]) begin
        ack_ff <= ack_sy_ff[2];
      end
      if (brst_sy_ff[1] == brst_sy_ff[2]) begin
        brst_ff <= brst_sy_ff[2];
      end
    end
  end

  // ------------------------------------------------------------------
  // Register port, four-phase
  // ------------------------------------------------------------------
  usbsrc_state_type state_ff;
  usbsrc_state_type nxt_state;
  logic             xdone_ff;
  logic [7:0]       rd_ff;
  logic [7:0]       shadow_ff;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dev_cs    <= 1'b0;
      o_dev_wr    <= 1'b0;
      o_dev_addr  <= 8'h00;
      o_dev_wdata <= 8'h00;
      xdone_ff    <= 1'b0;
      rd_ff       <= 8'h00;
    end else begin
      xdone_ff <= 1'b0;
      if (!o_dev_cs && !ack_ff && !xdone_ff && is_xfer(state_ff)) begin
        o_dev_cs    <= 1'b1;
        o_dev_wr    <= (state_ff != ST_INIT_RD) && (state_ff != ST_SV_RD);
        o_dev_addr  <= DEV_SRC_ADDR;
        o_dev_wdata <= wr_value(state_ff);
      end else if (o_dev_cs && ack_ff) begin
        // Data is stable while the acknowledge stands.
        o_dev_cs <= 1'b0;
        xdone_ff <= 1'b1;
        if (!o_dev_wr) begin
          rd_ff <= i_dev_rdata;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shadow_ff <= 8'h00;
    end else if (brst_ff) begin
      shadow_ff <= 8'h00;
    end else if (xdone_ff && o_dev_wr) begin
      shadow_ff <= o_dev_wdata & CTL_MASK;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] sess_ff;
  logic             stop_ff;
  logic             tmr_zero;

  assign tmr_zero = (tmr_ff == '0);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:      if (sw.start) nxt_state = ST_EN_WR;
      ST_EN_WR:     if (xdone_ff) nxt_state = ST_INIT_CLR;
      ST_INIT_CLR:  if (xdone_ff) nxt_state = ST_INIT_WAIT;
      ST_INIT_WAIT: if (tmr_zero) nxt_state = ST_INIT_RD;
      ST_INIT_RD:   if (xdone_ff) nxt_state = rd_ff[INIT_BIT] ?
                                    ST_OFF_FAIL : ST_DP_ON;
      ST_DP_ON:     if (xdone_ff) nxt_state = ST_DP_WAIT;
      ST_DP_WAIT:   if (tmr_zero) nxt_state = ST_DP_OFF;
      ST_DP_OFF:    if (xdone_ff) nxt_state = ST_VP_ON;
      ST_VP_ON:     if (xdone_ff) nxt_state = ST_VP_WAIT;
      ST_VP_WAIT:   if (tmr_zero) nxt_state = ST_VP_OFF;
      ST_VP_OFF:    if (xdone_ff) nxt_state = sw.disc_en ?
                                    ST_DISC_ON : ST_SV_CLR;
      ST_DISC_ON:   if (xdone_ff) nxt_state = ST_DISC_WAIT;
      ST_DISC_WAIT: if (tmr_zero) nxt_state = ST_DISC_OFF;
      ST_DISC_OFF:  if (xdone_ff) nxt_state = ST_SV_CLR;
      ST_SV_CLR:    if (xdone_ff) nxt_state = ST_SV_WAIT;
      ST_SV_WAIT:   if (tmr_zero) nxt_state = ST_SV_RD;
      // no flag within 5 s fails
      ST_SV_RD: begin
        if (xdone_ff) begin
          if (rd_ff[SV_BIT])        nxt_state = ST_OFF_OK;
          else if (sess_ff == '0)   nxt_state = ST_OFF_FAIL;
          else                      nxt_state = ST_SV_WAIT;
        end
      end
      ST_OFF_OK, ST_OFF_FAIL: if (xdone_ff) nxt_state = ST_IDLE;
      default:      nxt_state = ST_IDLE;
    endcase
    // A stop request is honoured between port transfers only.
    if (stop_ff && is_xfer(state_ff) == 1'b0 && state_ff != ST_IDLE) begin
      nxt_state = ST_OFF_FAIL;
    end else if (stop_ff && xdone_ff && state_ff != ST_OFF_FAIL &&
                 state_ff != ST_OFF_OK) begin
      nxt_state = ST_OFF_FAIL;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tmr_ff <= '0;
    end else if (nxt_state != state_ff) begin
      case (nxt_state)
        ST_INIT_WAIT: tmr_ff <= TMR_W'(P_INIT_CYC);
        ST_DP_WAIT:   tmr_ff <= TMR_W'(P_DP_CYC);
        ST_VP_WAIT:   tmr_ff <= TMR_W'(P_VP_CYC);
        ST_DISC_WAIT: tmr_ff <= TMR_W'(P_DISC_CYC);
        ST_SV_WAIT:   tmr_ff <= TMR_W'(P_POLL_CYC);
        default:      tmr_ff <= '0;
      endcase
    end else if (!tmr_zero) begin
      tmr_ff <= tmr_ff - TMR_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sess_ff <= '0;
    end else if (state_ff == ST_SV_CLR && xdone_ff) begin
      sess_ff <= TMR_W'(P_SESS_CYC);
    end else if (sess_ff != '0) begin
      sess_ff <= sess_ff - TMR_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // Results
  // ------------------------------------------------------------------
  logic done_ff;
  logic ok_ff;
  logic initf_ff;
  logic tout_ff;
  logic brstf_ff;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stop_ff  <= 1'b0;
      done_ff  <= 1'b0;
      ok_ff    <= 1'b0;
      initf_ff <= 1'b0;
      tout_ff  <= 1'b0;
      brstf_ff <= 1'b0;
      o_pullup_connect <= 1'b0;
    end else begin
      if (state_ff == ST_IDLE && sw.start) begin
        {stop_ff, done_ff, ok_ff, initf_ff, tout_ff} <= 5'h00;
        brstf_ff         <= 1'b0;
        o_pullup_connect <= 1'b0;
      end else begin
        if (state_ff != ST_IDLE && (sw.abort || brst_ff)) begin
          stop_ff <= 1'b1;
        end
        if (brst_ff && state_ff != ST_IDLE) begin
          brstf_ff <= 1'b1;
        end
        if (state_ff == ST_INIT_RD && xdone_ff && rd_ff[INIT_BIT]) begin
          initf_ff <= 1'b1;
        end
        if (state_ff == ST_SV_RD && xdone_ff && !rd_ff[SV_BIT] &&
            sess_ff == '0) begin
          tout_ff <= 1'b1;
        end
        if ((state_ff == ST_OFF_OK || state_ff == ST_OFF_FAIL) &&
            xdone_ff) begin
          done_ff <= 1'b1;
          stop_ff <= 1'b0;
          ok_ff   <= (state_ff == ST_OFF_OK);
          o_pullup_connect <= (state_ff == ST_OFF_OK);
        end
      end
    end
  end

  assign sw.busy      = (state_ff != ST_IDLE);
  assign sw.done      = done_ff;
  assign sw.success   = ok_ff;
  assign sw.init_fail = initf_ff;
  assign sw.timeout   = tout_ff;
  assign sw.busrst    = brstf_ff;
  assign sw.state     = state_ff;
  assign sw.last_rd   = rd_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [TMR_W-1:0] dp_len_ff;
  logic [TMR_W-1:0] vp_len_ff;
  logic [TMR_W-1:0] span_ff;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dp_len_ff <= '0;
      vp_len_ff <= '0;
      span_ff   <= '0;
    end else begin
      dp_len_ff <= shadow_ff[DP_BIT] ? dp_len_ff + TMR_W'(1) : '0;
      vp_len_ff <= shadow_ff[VP_BIT] ? vp_len_ff + TMR_W'(1) : '0;
      if (shadow_ff[DP_BIT] || shadow_ff[VP_BIT]) begin
        span_ff <= span_ff + TMR_W'(1);
      end else if (state_ff == ST_IDLE) begin
        span_ff <= '0;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  dp_pulse_len_a: assert property ($fell(shadow_ff[DP_BIT])
    && !brst_ff |-> $past(dp_len_ff) >= TMR_W'(P_DPMIN_CYC))
    else $error("data-line pulse shorter than 5 ms");
  vp_pulse_len_a: assert property ($fell(shadow_ff[VP_BIT])
    && !brst_ff |-> $past(vp_len_ff) >= TMR_W'(P_VPMIN_CYC))
    else $error("VBUS pulse too short");
  pulse_order_a: assert property ($rose(shadow_ff[VP_BIT])
    |-> !shadow_ff[DP_BIT])
    else $error("VBUS pulse started during data-line pulse");
  pulse_span_a: assert property (shadow_ff[DP_BIT] || shadow_ff[VP_BIT]
    |-> span_ff < TMR_W'(P_PMAX_CYC))
    else $error("pulse phases exceed 100 ms");
  init_wait_a: assert property ($rose(state_ff == ST_INIT_RD)
    && !stop_ff |-> $past(state_ff) == ST_INIT_WAIT)
    else $error("initial-condition flag read without wait");
  init_abort_a: assert property (state_ff == ST_INIT_RD && xdone_ff &&
    rd_ff[INIT_BIT] |=> state_ff == ST_OFF_FAIL)
    else $error("request continued after violation");
  disable_clr_a: assert property (o_dev_cs && o_dev_wr &&
    !o_dev_wdata[DR_EN_BIT] |-> o_dev_wdata[DP_BIT] == 1'b0 &&
    o_dev_wdata[VP_BIT] == 1'b0)
    else $error("dual-role disabled with a pulse bit set");
  disc_clear_a: assert property ($rose(done_ff)
    |-> shadow_ff[DISC_BIT] == 1'b0)
    else $error("discharge still on at the end");
  pullup_order_a: assert property ($rose(o_pullup_connect)
    |-> !shadow_ff[DR_EN_BIT] && ok_ff)
    else $error("pull-up connected while dual-role enabled");
  port_hold_a: assert property (o_dev_cs && !ack_ff
    |=> o_dev_cs && $stable(o_dev_wdata) && $stable(o_dev_wr))
    else $error("port request changed before acknowledge");

  success_c: cover property (state_ff == ST_OFF_OK && xdone_ff);
  init_fail_c: cover property ($rose(initf_ff));
  timeout_c: cover property ($rose(tout_ff));
  busrst_c: cover property ($rose(brstf_ff));
endmodule

// File: tb/usbsrc_dev_model.sv
/* Model of the peripheral's session request register.
   Assumes the controller's four-phase cs/ack port on one clock. */
`timescale 1ns/1ps
module usbsrc_dev_model
  import usbsrc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_cs,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_vbus_ok,
  input  wire logic       i_init_bad,
  input  wire logic       i_bus_reset,
  output logic            o_ack,
  output logic      [7:0] o_rdata
);
  logic [7:0] reg_ff;
  logic [7:0] nxt_reg;
  // A released read bus shows the inverse, so stale data never passes.
  assign o_rdata = o_ack ? reg_ff : ~reg_ff;
  always_comb begin
    nxt_reg = reg_ff;
    if (i_cs && !o_ack && i_wr && i_addr == DEV_SRC_ADDR) begin
      nxt_reg = (reg_ff & ~CTL_MASK) | (i_wdata & CTL_MASK);
      nxt_reg = nxt_reg & ~(i_wdata & 8'h18);
    end
    if (i_init_bad) nxt_reg[INIT_BIT] = 1'b1;
    if (i_vbus_ok) nxt_reg[SV_BIT] = 1'b1;
    if (i_bus_reset) nxt_reg = nxt_reg & ~CTL_MASK;
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reg_ff <= 8'h00;
      o_ack <= 1'b0;
    end else begin
      reg_ff <= nxt_reg;
      o_ack <= i_cs;
    end
  end
endmodule

// File: tb/tb_usbsrc_ctrl.sv
/* Self-checking bench of the session request controller.
   Assumes the shortened counts given at the instance. */
`timescale 1ns/1ps
module tb_usbsrc_ctrl;
  import usbsrc_pkg::*;
  logic        i_sys_clk = 0, i_resetn = 0, i_psel = 0, i_penable = 0;
  logic        i_pwrite = 0, o_pready, o_pslverr, o_dev_cs, o_dev_wr;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, st;
  logic [7:0]  o_dev_addr, o_dev_wdata, i_dev_rdata, wlog[$];
  logic        i_dev_ack, i_bus_reset = 0, o_pullup_connect, perr;
  logic        vbus_ok = 0, init_bad = 0;
  int          err_count = 0, compares = 0, cyc = 0;
  usbsrc_ctrl #(.P_INIT_CYC(20), .P_DP_CYC(60), .P_VP_CYC(200),
    .P_DISC_CYC(30), .P_SESS_CYC(2000))
  usbsrc_ctrl_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_paddr(i_paddr), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_dev_cs(o_dev_cs),
    .o_dev_wr(o_dev_wr), .o_dev_addr(o_dev_addr),
    .o_dev_wdata(o_dev_wdata), .i_dev_rdata(i_dev_rdata),
    .i_dev_ack(i_dev_ack), .i_bus_reset(i_bus_reset),
    .o_pullup_connect(o_pullup_connect));
  usbsrc_dev_model usbsrc_dev_model_inst (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .i_cs(o_dev_cs), .i_wr(o_dev_wr),
    .i_addr(o_dev_addr), .i_wdata(o_dev_wdata), .i_vbus_ok(vbus_ok),
    .i_init_bad(init_bad), .i_bus_reset(i_bus_reset),
    .o_ack(i_dev_ack), .o_rdata(i_dev_rdata));
  // --------------------------------------------------------------
  // Clock, write log and hang guard
  // --------------------------------------------------------------
  initial forever #25 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    if (o_dev_cs && o_dev_wr && !i_dev_ack) wlog.push_back(o_dev_wdata);
    if (o_dev_cs && !i_dev_ack) chk(o_dev_addr, DEV_SRC_ADDR);
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
  task report_and_stop();
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_paddr <= a;
    i_pwrite <= w;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1) @(posedge i_sys_clk);
    st = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task wait_done(input logic [31:0] est);
    do apb(STAT_OFS, 1'b0, 32'h0); while (st[S_DONE_BIT] !== 1'b1);
    chk(st & 32'h3F, est);
  endtask
  task run(input logic [31:0] c, input logic [7:0] e[$], input logic [31:0] s);
    wlog.delete();
    apb(CTRL_OFS, 1'b1, c);
    wait_done(s);
    chk(wlog.size(), e.size());
    foreach (e[i]) chk(wlog[i], e[i]);
  endtask
  task stop_mid(input logic brst, input logic [31:0] s);
    apb(CTRL_OFS, 1'b1, 32'h1);
    repeat (100) @(posedge i_sys_clk);
    if (brst) i_bus_reset <= 1'b1;
    else apb(CTRL_OFS, 1'b1, 32'h4);
    repeat (10) @(posedge i_sys_clk);
    i_bus_reset <= 1'b0;
    wait_done(s);
    chk(wlog[$], 8'h00);
  endtask
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    apb(STAT_OFS, 1'b0, 32'h0);
    chk(st, 32'h0);
    apb(12'h008, 1'b0, 32'h0);
    chk(perr, 1'b1);
    init_bad <= 1'b1;
    run(32'h1, '{8'h01, 8'h09, 8'h00}, 32'h0A);
    init_bad <= 1'b0;
    vbus_ok <= 1'b1;
    run(32'h3, '{8'h01, 8'h09, 8'h21, 8'h01, 8'h03, 8'h01, 8'h05,
      8'h01, 8'h11, 8'h00}, 32'h06);
    chk(o_pullup_connect, 1'b1);
    apb(CTRL_OFS, 1'b0, 32'h0);
    chk(st, 32'h2);
    vbus_ok <= 1'b0;
    run(32'h1, '{8'h01, 8'h09, 8'h21, 8'h01, 8'h03, 8'h01, 8'h11,
      8'h00}, 32'h12);
    chk(o_pullup_connect, 1'b0);
    stop_mid(1'b0, 32'h02);
    stop_mid(1'b1, 32'h22);
    report_and_stop();
  end
endmodule
